// [hdl/coe_pkg.sv]
/*
 * Shared constants and types for the capture overrun and edge control block.
 * Assumes a 32-bit AHB-Lite register bus and a 16-bit capture timer on the
 * same clock as the bus.
 */
package coe_pkg;

    // Register decode width and byte offsets
    localparam int              COE_ADDR_W      = 8;
    localparam logic [7:0]      COE_CTRL_OFS    = 8'h00;
    localparam logic [7:0]      COE_CH3_LO_OFS  = 8'h04;
    localparam logic [7:0]      COE_CH3_HI_OFS  = 8'h08;
    localparam logic [7:0]      COE_CH4_LO_OFS  = 8'h0c;
    localparam logic [7:0]      COE_CH4_HI_OFS  = 8'h10;
    localparam logic [7:0]      COE_TIMER_OFS   = 8'h14;

    // Control/status field positions
    localparam int              COE_PWM_BIT     = 0;
    localparam int              COE_ED3_LSB     = 1;
    localparam int              COE_ED4_LSB     = 3;
    localparam int              COE_OVF3_BIT    = 5;
    localparam int              COE_OVF4_BIT    = 6;
    localparam int              COE_RSVD_BIT    = 7;

    // Reset values
    localparam logic [7:0]      COE_CTRL_RST    = 8'h00;
    localparam logic [15:0]     COE_CAP_RST     = 16'h0000;
    localparam logic [31:0]     COE_RDATA_RST   = 32'h0000_0000;

    // Rising edges counted per event in divide-by-four mode, minus one
    localparam logic [1:0]      COE_PRESCALE_LAST = 2'h3;

    // Capture trigger selection
    typedef enum logic [1:0] {
        COE_EDGE_FALL  = 2'b00,
        COE_EDGE_RISE  = 2'b01,
        COE_EDGE_RISE4 = 2'b10,
        COE_EDGE_OFF   = 2'b11
    } coe_edge_t;

    // Status one capture channel hands to the register file
    typedef struct packed {
        logic [15:0] value;
        logic        full;
        logic        overrun;
    } coe_cap_t;

endpackage

// [hdl/coe_capture_chan.sv]
/*
 * One input-capture channel: pin synchroniser, edge selection, capture
 * holding register with read tracking and overrun flag.
 * Assumes the pin is asynchronous and the timer is on hclk.
 */
`timescale 1ns/10ps
module coe_capture_chan
    import coe_pkg::*;
(
    input  wire logic        hclk,        // System clock
    input  wire logic        hresetn,     // Async reset, active low
    input  wire logic        cap_pin,     // Capture input pin
    input  wire coe_edge_t   edge_sel,    // Trigger selection
    input  wire logic [15:0] timer_val,   // Current capture timer count
    input  wire logic        rd_lo,       // Low byte read pulse
    input  wire logic        rd_hi,       // High byte read pulse
    output coe_cap_t         status       // Held value and flags
);

    typedef struct packed {
        logic        sync1;
        logic        sync2;
        logic        prev;
        coe_edge_t   mode;
        logic [1:0]  pre_cnt;
        logic [15:0] value;
        logic        full;
        logic        lo_seen;
        logic        hi_seen;
        logic        overrun;
    } coe_chan_st_t;

    coe_chan_st_t st_r;
    coe_chan_st_t st_nxt;
    logic         rise;
    logic         fall;
    logic         ev;
    logic         release_pair;

    // Edge detect on synchronised pin
    assign rise         = st_r.sync2 & ~st_r.prev;
    assign fall         = ~st_r.sync2 & st_r.prev;
    // Pair is free once both bytes have been read
    assign release_pair = st_r.full & (st_r.lo_seen | rd_lo) & (st_r.hi_seen | rd_hi); // RQ4

    // Event selection
    always_comb begin
        ev = 1'b0;
        if (edge_sel == st_r.mode) begin
            case (edge_sel)
                COE_EDGE_FALL:  ev = fall;                                           // RQ8
                COE_EDGE_RISE:  ev = rise;                                           // RQ8
                COE_EDGE_RISE4: ev = rise && (st_r.pre_cnt == COE_PRESCALE_LAST);    // RQ8
                default:        ev = 1'b0;
            endcase
        end
    end

    // Next state
    always_comb begin
        st_nxt       = st_r;
        st_nxt.sync1 = cap_pin;
        st_nxt.sync2 = st_r.sync1;
        st_nxt.prev  = st_r.sync2;
        st_nxt.mode  = edge_sel;
        // Prescaler restarts whenever the mode changes
        if (edge_sel != st_r.mode) begin
            st_nxt.pre_cnt = 2'h0;
        end else if (edge_sel == COE_EDGE_RISE4 && rise) begin
            st_nxt.pre_cnt = st_r.pre_cnt + 2'h1;                                    // RQ8
        end
        // Byte read tracking while a value is held
        if (st_r.full) begin
            if (rd_lo) begin
                st_nxt.lo_seen = 1'b1;
            end
            if (rd_hi) begin
                st_nxt.hi_seen = 1'b1;
            end
        end
        if (release_pair) begin
            st_nxt.full    = 1'b0;
            st_nxt.overrun = 1'b0;
            st_nxt.lo_seen = 1'b0;
            st_nxt.hi_seen = 1'b0;
        end
        // Capture or overrun
        if (ev) begin
            if (st_r.full && !release_pair) begin                                   // RQ3
                st_nxt.overrun = 1'b1;                                               // RQ2
            end else begin
                st_nxt.value   = timer_val;                                          // RQ5
                st_nxt.full    = 1'b1;
                st_nxt.lo_seen = 1'b0;
                st_nxt.hi_seen = 1'b0;
            end
        end
    end

    // State register
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            st_r <= '{sync1: 1'b0, sync2: 1'b0, prev: 1'b0, mode: COE_EDGE_FALL, pre_cnt: 2'h0,
                      value: COE_CAP_RST, full: 1'b0, lo_seen: 1'b0, hi_seen: 1'b0, overrun: 1'b0};
        end else begin
            st_r <= st_nxt;
        end
    end

    assign status = '{value: st_r.value, full: st_r.full, overrun: st_r.overrun};

    load_value_a: assert property (@(posedge hclk) disable iff (!hresetn) // RQ5
        (ev && (!st_r.full || release_pair)) |=> (st_r.value == $past(timer_val)))
        else $error("capture did not load the timer count");
    hold_oldest_a: assert property (@(posedge hclk) disable iff (!hresetn) // RQ3
        (st_r.full && !release_pair) |=> $stable(st_r.value))
        else $error("held capture value changed before release");
    ovf_set_a: assert property (@(posedge hclk) disable iff (!hresetn) // RQ2
        (ev && st_r.full && !release_pair) |=> st_r.overrun)
        else $error("overrun not flagged on event while held");
    block_until_read_a: assert property (@(posedge hclk) disable iff (!hresetn) // RQ4
        (st_r.full && !(st_r.lo_seen && st_r.hi_seen) && !rd_lo && !rd_hi) |=> st_r.full)
        else $error("capture pair released without both byte reads");
    ovf_means_held_a: assert property (@(posedge hclk) disable iff (!hresetn) // RQ6
        st_r.overrun |-> st_r.full)
        else $error("overrun flag set with no held capture");

endmodule

// [hdl/coe_capture_ctrl.sv]
/*
 * Capture overrun and edge control block: AHB-Lite register slave holding the
 * shared control/status byte and the capture byte pairs of channels three and
 * four, with one capture channel instance per pin.
 * Assumes a single AHB-Lite master, word transfers, and a capture timer that
 * runs on hclk.
 */
`timescale 1ns/10ps

// Behaviour
// RQ1: Control bit 7 reads zero, ignores writes
// RQ2: New event while pair unread sets overrun
// RQ3: Overrun keeps oldest unread capture value
// RQ4: Pair reloads only after both bytes read
// RQ5: Capture loads current capture timer count
// RQ6: Overrun flag reads one after overrun, else zero
// RQ7: Flags read-only; edge and PWM bits writable, reset zero
// RQ8: Channel three alike; edge field picks trigger
module coe_capture_ctrl
    import coe_pkg::*;
(
    input  wire logic        hclk,             // System clock, 125 MHz
    input  wire logic        hresetn,          // Async reset, active low
    input  wire logic        hsel,             // Slave select
    input  wire logic [31:0] haddr,            // Byte address
    input  wire logic [1:0]  htrans,           // Transfer type
    input  wire logic        hwrite,           // Write when high
    input  wire logic [2:0]  hsize,            // Transfer size, word only
    input  wire logic [31:0] hwdata,           // Write data
    input  wire logic        hready,           // Bus ready in
    output logic             hreadyout,        // Slave ready out
    output logic             hresp,            // Response, always OKAY
    output logic [31:0]      hrdata,           // Read data, registered
    input  wire logic [15:0] capture_timer,    // Free-running timer count
    input  wire logic        ch3_capture_pin,  // Channel three capture pin
    input  wire logic        ch4_capture_pin,  // Channel four capture pin
    output logic             third_pwm_enable  // PWM enable control bit
);

    // Bus and control state
    typedef struct packed {
        logic [31:0]           hrdata;
        logic                  wr_pend;
        logic [COE_ADDR_W-1:0] wr_addr;
        coe_edge_t             ed3;
        coe_edge_t             ed4;
        logic                  pwm;
    } coe_bus_st_t;

    coe_bus_st_t           st_r;
    coe_bus_st_t           st_nxt;
    coe_cap_t              cap3;
    coe_cap_t              cap4;
    logic                  acc;
    logic                  rd_acc;
    logic                  wr_acc;
    logic [COE_ADDR_W-1:0] a;
    logic                  rd3_lo;
    logic                  rd3_hi;
    logic                  rd4_lo;
    logic                  rd4_hi;
    logic [7:0]            ctrl_view;

    // Assemble the control/status byte
    function automatic logic [7:0] ctrl_byte(
        input coe_edge_t ed3,
        input coe_edge_t ed4,
        input logic      pwm,
        input logic      ovf3,
        input logic      ovf4
    );
        logic [7:0] v;
        v                                  = COE_CTRL_RST;
        v[COE_PWM_BIT]                     = pwm;
        v[COE_ED3_LSB+1:COE_ED3_LSB]       = ed3;
        v[COE_ED4_LSB+1:COE_ED4_LSB]       = ed4;
        v[COE_OVF3_BIT]                    = ovf3;
        v[COE_OVF4_BIT]                    = ovf4;
        v[COE_RSVD_BIT]                    = 1'b0;   // RQ1
        return v;
    endfunction

    // Read multiplexer, unmapped addresses read zero
    function automatic logic [31:0] reg_read(
        input logic [COE_ADDR_W-1:0] addr,
        input logic [7:0]            ctrl,
        input coe_cap_t              c3,
        input coe_cap_t              c4,
        input logic [15:0]           tmr
    );
        logic [31:0] d;
        d = COE_RDATA_RST;
        case (addr)
            COE_CTRL_OFS:   d = {24'h00_0000, ctrl};
            COE_CH3_LO_OFS: d = {24'h00_0000, c3.value[7:0]};
            COE_CH3_HI_OFS: d = {24'h00_0000, c3.value[15:8]};
            COE_CH4_LO_OFS: d = {24'h00_0000, c4.value[7:0]};
            COE_CH4_HI_OFS: d = {24'h00_0000, c4.value[15:8]};
            COE_TIMER_OFS:  d = {16'h0000, tmr};
            default:        d = COE_RDATA_RST;
        endcase
        return d;
    endfunction

    // Address phase qualification
    assign acc    = hsel & htrans[1] & hready;
    assign rd_acc = acc & ~hwrite;
    assign wr_acc = acc & hwrite;
    assign a      = haddr[COE_ADDR_W-1:0];

    // Byte read pulses tracked by the channels
    assign rd3_lo = rd_acc && (a == COE_CH3_LO_OFS);  // RQ4
    assign rd3_hi = rd_acc && (a == COE_CH3_HI_OFS);  // RQ4
    assign rd4_lo = rd_acc && (a == COE_CH4_LO_OFS);  // RQ4
    assign rd4_hi = rd_acc && (a == COE_CH4_HI_OFS);  // RQ4

    // Next state: apply pending write first so a following read sees it
    always_comb begin
        st_nxt         = st_r;
        st_nxt.wr_pend = wr_acc;
        st_nxt.wr_addr = a;
        if (st_r.wr_pend && (st_r.wr_addr == COE_CTRL_OFS)) begin
            // Flag bits and bit 7 are not written
            st_nxt.pwm = hwdata[COE_PWM_BIT];                              // RQ7
            st_nxt.ed3 = coe_edge_t'(hwdata[COE_ED3_LSB+1:COE_ED3_LSB]);   // RQ7
            st_nxt.ed4 = coe_edge_t'(hwdata[COE_ED4_LSB+1:COE_ED4_LSB]);   // RQ7
        end
        ctrl_view = ctrl_byte(st_nxt.ed3, st_nxt.ed4, st_nxt.pwm, cap3.overrun, cap4.overrun); // RQ6
        if (rd_acc) begin
            st_nxt.hrdata = reg_read(a, ctrl_view, cap3, cap4, capture_timer);
        end
    end

    // State register
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            st_r <= '{hrdata: COE_RDATA_RST, wr_pend: 1'b0, wr_addr: '0,
                      ed3: coe_edge_t'(COE_CTRL_RST[COE_ED3_LSB+1:COE_ED3_LSB]),
                      ed4: coe_edge_t'(COE_CTRL_RST[COE_ED4_LSB+1:COE_ED4_LSB]),
                      pwm: COE_CTRL_RST[COE_PWM_BIT]};                     // RQ7
        end else begin
            st_r <= st_nxt;
        end
    end

    // Zero-wait slave, always OKAY
    assign hreadyout        = 1'b1;
    assign hresp            = 1'b0;
    assign hrdata           = st_r.hrdata;
    assign third_pwm_enable = st_r.pwm;

    // Channel three capture
    coe_capture_chan u_ch3 (
        .hclk      (hclk),
        .hresetn   (hresetn),
        .cap_pin   (ch3_capture_pin),
        .edge_sel  (st_r.ed3),
        .timer_val (capture_timer),   // RQ5
        .rd_lo     (rd3_lo),
        .rd_hi     (rd3_hi),
        .status    (cap3)             // RQ8
    );

    // Channel four capture
    coe_capture_chan u_ch4 (
        .hclk      (hclk),
        .hresetn   (hresetn),
        .cap_pin   (ch4_capture_pin),
        .edge_sel  (st_r.ed4),
        .timer_val (capture_timer),   // RQ5
        .rd_lo     (rd4_lo),
        .rd_hi     (rd4_hi),
        .status    (cap4)
    );

    msb_zero_a: assert property (@(posedge hclk) disable iff (!hresetn) // RQ1
        (rd_acc && (a == COE_CTRL_OFS)) |=> (hrdata[COE_RSVD_BIT] == 1'b0))
        else $error("reserved control bit read as one");
    ovf_view_a: assert property (@(posedge hclk) disable iff (!hresetn) // RQ6
        (rd_acc && (a == COE_CTRL_OFS)) |=>
        (hrdata[COE_OVF4_BIT] == $past(cap4.overrun)) && (hrdata[COE_OVF3_BIT] == $past(cap3.overrun)))
        else $error("overrun flag read back wrong");
    ctrl_write_a: assert property (@(posedge hclk) disable iff (!hresetn) // RQ7
        (st_r.wr_pend && (st_r.wr_addr == COE_CTRL_OFS)) |=>
        ({st_r.ed4, st_r.ed3, st_r.pwm} == $past(hwdata[4:0])))
        else $error("control write not stored");

    // Read data per offset, from the state seen at the address edge; control fields from the state after it
    ctrl_fields_a: assert property (@(posedge hclk) disable iff (!hresetn) // RQ7
        (rd_acc && (a == COE_CTRL_OFS)) |=> (hrdata[4:0] == {st_r.ed4, st_r.ed3, st_r.pwm}))
        else $error("control fields read back wrong");
    ctrl_upper_a: assert property (@(posedge hclk) disable iff (!hresetn) // RQ1
        (rd_acc && (a == COE_CTRL_OFS)) |=> (hrdata[31:8] == 24'h00_0000))
        else $error("control read has bits above the byte");
    ch3_lo_read_a: assert property (@(posedge hclk) disable iff (!hresetn) // RQ5
        rd3_lo |=> (hrdata == {24'h00_0000, $past(cap3.value[7:0])}))
        else $error("channel three low byte read wrong");
    ch3_hi_read_a: assert property (@(posedge hclk) disable iff (!hresetn) // RQ5
        rd3_hi |=> (hrdata == {24'h00_0000, $past(cap3.value[15:8])}))
        else $error("channel three high byte read wrong");
    ch4_lo_read_a: assert property (@(posedge hclk) disable iff (!hresetn) // RQ5
        rd4_lo |=> (hrdata == {24'h00_0000, $past(cap4.value[7:0])}))
        else $error("channel four low byte read wrong");
    ch4_hi_read_a: assert property (@(posedge hclk) disable iff (!hresetn) // RQ5
        rd4_hi |=> (hrdata == {24'h00_0000, $past(cap4.value[15:8])}))
        else $error("channel four high byte read wrong");
    timer_read_a: assert property (@(posedge hclk) disable iff (!hresetn) // RQ5
        (rd_acc && (a == COE_TIMER_OFS)) |=> (hrdata == {16'h0000, $past(capture_timer)}))
        else $error("timer read wrong");

    // Control fields move only through a control write
    ctrl_keep_a: assert property (@(posedge hclk) disable iff (!hresetn) // RQ7
        !(st_r.wr_pend && (st_r.wr_addr == COE_CTRL_OFS)) |=> $stable({st_r.ed4, st_r.ed3, st_r.pwm}))
        else $error("control field changed without a write");
    pwm_out_a: assert property (@(posedge hclk) disable iff (!hresetn) // RQ7
        (st_r.wr_pend && (st_r.wr_addr == COE_CTRL_OFS)) |=> (third_pwm_enable == $past(hwdata[COE_PWM_BIT])))
        else $error("pwm enable output not written");

endmodule

// [dv/coe_capture_far.sv]
/*
 * Far-side model: the capture timer count and the two capture input pins.
 * Assumes the bench calls its tasks right after a rising edge of hclk.
 */
`timescale 1ns/10ps
module coe_capture_far (
    input  wire logic   hclk,     // System clock
    output logic [15:0] timer_q,  // Capture timer count
    output logic [1:0]  pins      // Capture pins, bit 0 channel three
);
    // Timer held at a set value so the expected capture is exact
    initial begin
        timer_q = 16'h0000;
        pins    = 2'b00;
    end
    // New timer count, changed just after an edge
    task automatic set_timer(input logic [15:0] v);
        timer_q <= v;
        @(posedge hclk);
    endtask
    // One pin level change, then room for sync, detect and load
    task automatic pin_to(input int ch, input logic lvl);
        pins[ch] <= lvl;
        repeat (8) @(posedge hclk);
    endtask
    // Rising then falling pin edge
    task automatic pulse(input int ch);
        pin_to(ch, 1'b1);
        pin_to(ch, 1'b0);
    endtask
endmodule

// [dv/test_capture_overrun_edge_control.sv]
/*
 * Self-checking bench for the capture overrun and edge control block.
 * Assumes the far-side model drives the timer and pins; AHB-Lite master here.
 */
`timescale 1ns/10ps
module test_capture_overrun_edge_control
    import coe_pkg::*;
();
    logic        hclk;
    logic        hresetn;
    logic        hsel;
    logic        hwrite;
    logic [31:0] haddr;
    logic [31:0] hwdata;
    logic [31:0] hrdata;
    logic [31:0] rd;
    logic [31:0] w;
    logic [1:0]  htrans;
    logic [2:0]  hsize;
    logic        hreadyout;
    logic        hresp;
    logic        third_pwm_enable;
    logic [15:0] capture_timer;
    logic [1:0]  pins;
    logic [15:0] t1;
    logic [15:0] t2;
    logic [31:0] seed;
    int          n_errors;
    int          checks_done;
    int          cycles;

    coe_capture_ctrl dut (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .capture_timer(capture_timer),
        .ch3_capture_pin(pins[0]), .ch4_capture_pin(pins[1]), .third_pwm_enable(third_pwm_enable)
    );
    coe_capture_far far (.hclk(hclk), .timer_q(capture_timer), .pins(pins));

    // Clock of 8 ns
    always #4 hclk = ~hclk;

    // Xorshift source of random values
    function automatic logic [15:0] rnd16();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed[15:0];
    endfunction
    // Expected control readback: bit 7 zero, flags as given
    function automatic logic [31:0] ctrl_exp(input logic [31:0] v, input logic o3, input logic o4);
        return {24'h000000, 1'b0, o4, o3, v[4:0]};
    endfunction
    // Control word with one channel's edge field set
    function automatic logic [31:0] mode_w(input int ch, input logic [1:0] m);
        return (ch != 0) ? {27'h0, m, 3'h0} : {29'h0, m, 1'b0};
    endfunction
    function automatic logic [7:0] lo_ofs(input int ch);
        return (ch != 0) ? COE_CH4_LO_OFS : COE_CH3_LO_OFS;
    endfunction
    function automatic logic [7:0] hi_ofs(input int ch);
        return (ch != 0) ? COE_CH4_HI_OFS : COE_CH3_HI_OFS;
    endfunction

    // Compare and count
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            n_errors++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    // One single AHB-Lite transfer, entered just after an edge
    task automatic ahb(input logic wr_en, input logic [7:0] a, input logic [31:0] wd,
                       output logic [31:0] rdv);
        hsel   <= 1'b1;
        htrans <= 2'b10;
        haddr  <= {24'h000000, a};
        hwrite <= wr_en;
        @(posedge hclk);
        while (hreadyout !== 1'b1) @(posedge hclk);
        hsel   <= 1'b0;
        htrans <= 2'b00;
        hwdata <= wd;
        @(posedge hclk);
        while (hreadyout !== 1'b1) @(posedge hclk);
        rdv = hrdata;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        ahb(1'b1, a, d, rd);
    endtask
    task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
        ahb(1'b0, a, 32'h0, rd);
        check(rd, exp);
        check({31'h0, hresp}, 32'h0);
    endtask
    // Low then high byte of a capture pair
    task automatic capchk(input int ch, input logic [15:0] exp);
        rdchk(lo_ofs(ch), {24'h0, exp[7:0]});
        rdchk(hi_ofs(ch), {24'h0, exp[15:8]});
    endtask
    // Counts, verdict, end of run
    task automatic conclude();
        $display("Checks %0d, errors %0d", checks_done, n_errors);
        if (n_errors == 0 && checks_done > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    // Hang guard
    always @(posedge hclk) begin
        cycles++;
        if (cycles == 20000) begin
            n_errors++;
            conclude();
        end
    end

    // Main sequence
    initial begin
        hclk = 1'b0;
        hresetn = 1'b0;
        hsel = 1'b0;
        haddr = 32'h0;
        htrans = 2'b00;
        hwrite = 1'b0;
        hsize = 3'b010;
        hwdata = 32'h0;
        seed = 32'd42888;
        n_errors = 0;
        checks_done = 0;
        cycles = 0;
        repeat (4) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        rdchk(COE_CTRL_OFS, 32'h0);
        check({31'h0, third_pwm_enable}, 32'h0);
        // Random control writes, first one all ones
        for (int i = 0; i < 6; i++) begin
            w = (i == 0) ? 32'hffffffff : {rnd16(), rnd16()};
            wr(COE_CTRL_OFS, w);
            rdchk(COE_CTRL_OFS, ctrl_exp(w, 1'b0, 1'b0));
            check({31'h0, third_pwm_enable}, {31'h0, w[0]});
        end
        // Overrun, hold of oldest value, release after both bytes
        for (int ch = 0; ch < 2; ch++) begin
            wr(COE_CTRL_OFS, mode_w(ch, COE_EDGE_RISE));
            t1 = rnd16();
            far.set_timer(t1);
            far.pulse(ch);
            far.set_timer(rnd16());
            far.pulse(ch);
            rdchk(COE_CTRL_OFS, ctrl_exp(mode_w(ch, COE_EDGE_RISE), ch == 0, ch == 1));
            rdchk(lo_ofs(ch), {24'h0, t1[7:0]});
            far.set_timer(rnd16());
            far.pulse(ch);
            rdchk(hi_ofs(ch), {24'h0, t1[15:8]});
            rdchk(COE_CTRL_OFS, ctrl_exp(mode_w(ch, COE_EDGE_RISE), 1'b0, 1'b0));
            t1 = rnd16();
            far.set_timer(t1);
            far.pulse(ch);
            capchk(ch, t1);
        end
        // Falling edge mode takes the fall, not the rise
        wr(COE_CTRL_OFS, mode_w(0, COE_EDGE_FALL));
        far.set_timer(rnd16());
        far.pin_to(0, 1'b1);
        t2 = rnd16();
        far.set_timer(t2);
        far.pin_to(0, 1'b0);
        capchk(0, t2);
        // Every fourth rising edge
        wr(COE_CTRL_OFS, mode_w(1, COE_EDGE_RISE4));
        far.set_timer(rnd16());
        repeat (3) far.pulse(1);
        t2 = rnd16();
        far.set_timer(t2);
        far.pulse(1);
        capchk(1, t2);
        // Disabled code takes nothing, so no overrun afterwards
        wr(COE_CTRL_OFS, mode_w(0, COE_EDGE_OFF));
        far.set_timer(rnd16());
        far.pulse(0);
        wr(COE_CTRL_OFS, mode_w(0, COE_EDGE_RISE));
        t2 = rnd16();
        far.set_timer(t2);
        far.pulse(0);
        rdchk(COE_CTRL_OFS, ctrl_exp(mode_w(0, COE_EDGE_RISE), 1'b0, 1'b0));
        capchk(0, t2);
        rdchk(COE_TIMER_OFS, {16'h0, t2});
        rdchk(8'h40, 32'h0);
        // Reset in mid-run clears the control byte
        wr(COE_CTRL_OFS, 32'h1f);
        hresetn <= 1'b0;
        repeat (2) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        rdchk(COE_CTRL_OFS, 32'h0);
        check({31'h0, third_pwm_enable}, 32'h0);
        conclude();
    end
endmodule
